/* File: mma_addr_path.v */
// Memory address register, save and restore, modification and distribution.
`timescale 1ns/10ps
`default_nettype none
`include "mma_defs.vh"

module mma_addr_path #(
	parameter ADDR_W = `MMA_ADDR_W,
	parameter WORD_W = `MMA_WORD_W
) (
	input  wire              sys_clk_in,
	input  wire              rst_in,
	input  wire              addr_mode_line_high_in,
	input  wire              addr_mode_line_mid_in,
	input  wire              addr_mode_line_low_in,
	input  wire [ADDR_W-1:0] main_exchange_bus_in,
	input  wire [ADDR_W-1:0] field_address_reg_in,
	input  wire              memory_rw_micro_start_in,
	input  wire              memory_rw_micro_done_in,
	input  wire              microword_increment_in,
	input  wire              fetch_flag_in,
	input  wire              transfer_direction_sign_in,
	input  wire              refresh_grant_in,
	input  wire [WORD_W-1:0] refresh_addr_in,
	input  wire [7:0]        write_data_in,
	input  wire [7:0]        read_data_in,
	output reg  [ADDR_W-1:0] memory_address_reg_out,
	output reg               data_role_out,
	output reg  [WORD_W-1:0] mod0_addr_out,
	output reg  [WORD_W-1:0] mod1_addr_out,
	output reg  [WORD_W-1:0] mod2_addr_out,
	output reg  [WORD_W-1:0] mod3_addr_out,
	output reg  [3:0]        modified_sel_out,
	output reg  [2:0]        rotate_bits_out,
	output reg  [7:0]        write_rot_out,
	output reg  [7:0]        read_rot_out
);

	localparam [2:0] ST_MICRO = 3'h1;
	localparam [2:0] ST_DATA  = 3'h2;
	localparam [2:0] ST_BAD   = 3'h4;

	// Place bit k of a byte at location (sel - k) modulo 8, location 0 highest.
	function [7:0] rot_byte;
		input [7:0] din;
		input [2:0] sel;
		reg   [2:0] src;
		integer     j;
		begin
			rot_byte = 8'h00;
			for (j = 0; j < 8; j = j + 1) begin
				src = sel - j[2:0];
				rot_byte[7 - j] = din[src];
			end
		end
	endfunction

	// Bring the bit at location (sel - k) modulo 8 back to data bit k.
	function [7:0] unrot_byte;
		input [7:0] din;
		input [2:0] sel;
		reg   [2:0] loc;
		integer     j;
		begin
			unrot_byte = 8'h00;
			for (j = 0; j < 8; j = j + 1) begin
				loc = sel - j[2:0];
				unrot_byte[j] = din[3'h7 - loc];
			end
		end
	endfunction

	// Action of the mode lines; unlisted codes fall to no operation.
	function [2:0] mode_decode;
		input [2:0] lines;
		begin
			case (lines)
				`MMA_MODE_LOAD: begin
					mode_decode = `MMA_MODE_LOAD;
				end
				`MMA_MODE_ADD: begin
					mode_decode = `MMA_MODE_ADD;
				end
				`MMA_MODE_SUB: begin
					mode_decode = `MMA_MODE_SUB;
				end
				default: begin
					mode_decode = `MMA_MODE_NOP;
				end
			endcase
		end
	endfunction

	reg  [ADDR_W-1:0] mar_q;
	reg  [ADDR_W-1:0] mar_d;
	reg  [ADDR_W-1:0] save_q;
	reg  [ADDR_W-1:0] save_d;
	reg  [2:0]        state_q;
	reg  [2:0]        state_d;
	reg  [2:0]        mode;
	reg  [`MMA_KEY_W-1:0] key_d;
	reg  [WORD_W-1:0] word_n;
	reg  [WORD_W-1:0] word_mod;
	reg  [WORD_W-1:0] mod_addr [0:3];
	reg  [2:0]        rot_sel;
	wire [3:0]        sel_a;
	wire [3:0]        sel_b;
	wire [3:0]        sel_mod;
	integer           m;

	mma_dist u_dist (
		.transfer_direction_sign_in (transfer_direction_sign_in),
		.fetch_flag_in              (fetch_flag_in),
		.key_byte_bit3_in           (mar_q[`MMA_KB_BIT3]),
		.key_byte_bit4_in           (mar_q[`MMA_KB_BIT4]),
		.unmodified_sel_a_out       (sel_a),
		.unmodified_sel_b_out       (sel_b),
		.modified_sel_out           (sel_mod)
	);

	// Next value of the address register and the saved micro address.
	always @* begin
		mar_d = mar_q;
		save_d = save_q;
		state_d = state_q;
		key_d = mar_q[ADDR_W-1:`MMA_KEY_LSB];
		mode = mode_decode({addr_mode_line_high_in,
			addr_mode_line_mid_in, addr_mode_line_low_in});
		case (state_q)
			ST_MICRO: begin
				if (memory_rw_micro_start_in) begin
					save_d = mar_q;
					mar_d = field_address_reg_in;
					state_d = ST_DATA;
				end else begin
					case (mode)
						`MMA_MODE_LOAD: begin
							mar_d = main_exchange_bus_in;
						end
						`MMA_MODE_ADD: begin
							key_d = key_d + main_exchange_bus_in[ADDR_W-1:`MMA_KEY_LSB];
							mar_d = {key_d, mar_q[`MMA_KEY_LSB-1:0]};
						end
						`MMA_MODE_SUB: begin
							key_d = key_d - main_exchange_bus_in[ADDR_W-1:`MMA_KEY_LSB];
							mar_d = {key_d, mar_q[`MMA_KEY_LSB-1:0]};
						end
						default: begin
							if (microword_increment_in) begin
								mar_d = mar_q + ({{(ADDR_W-1){1'b0}}, 1'b1} << `MMA_INC_BIT);
							end
						end
					endcase
				end
			end
			ST_DATA: begin
				if (memory_rw_micro_done_in) begin
					mar_d = save_q;
					state_d = ST_MICRO;
				end else if (mode == `MMA_MODE_LOAD) begin
					mar_d = main_exchange_bus_in;
				end
			end
			default: begin
				state_d = ST_MICRO;
			end
		endcase
	end

	// Word address and the always-present modified word.
	always @* begin
		word_n = mar_q[ADDR_W-1:`MMA_WORD_LSB];
		if (transfer_direction_sign_in) begin
			word_mod = word_n - {{(WORD_W-1){1'b0}}, 1'b1};
		end else begin
			word_mod = word_n + {{(WORD_W-1){1'b0}}, 1'b1};
		end
		for (m = 0; m < 4; m = m + 1) begin
			if (refresh_grant_in) begin
				mod_addr[m] = refresh_addr_in;
			end else if (sel_mod[m]) begin
				mod_addr[m] = word_mod;
			end else if (sel_a[m] & sel_b[m]) begin
				mod_addr[m] = word_n;
			end else begin
				mod_addr[m] = word_n;
			end
		end
		// Fetch addresses lie on byte boundaries and need no rotation.
		if (fetch_flag_in) begin
			rot_sel = 3'h0;
		end else begin
			rot_sel = mar_q[`MMA_KEY_LSB-1:0];
		end
	end

	always @(posedge sys_clk_in) begin
		if (rst_in) begin
			mar_q                  <= `MMA_ADDR_RST;
			save_q                 <= `MMA_ADDR_RST;
			state_q                <= ST_MICRO;
			memory_address_reg_out <= `MMA_ADDR_RST;
			data_role_out          <= 1'b0;
			mod0_addr_out          <= `MMA_WORD_RST;
			mod1_addr_out          <= `MMA_WORD_RST;
			mod2_addr_out          <= `MMA_WORD_RST;
			mod3_addr_out          <= `MMA_WORD_RST;
			modified_sel_out       <= 4'h0;
			rotate_bits_out        <= 3'h0;
			write_rot_out          <= `MMA_BYTE_RST;
			read_rot_out           <= `MMA_BYTE_RST;
		end else begin
			mar_q                  <= mar_d;
			save_q                 <= save_d;
			state_q                <= state_d;
			memory_address_reg_out <= mar_d;
			data_role_out          <= (state_d == ST_DATA);
			// In a fetch, modules 0 to 3 all carry the same word n unless refresh is granted.
			mod0_addr_out          <= mod_addr[0];
			mod1_addr_out          <= mod_addr[1];
			mod2_addr_out          <= mod_addr[2];
			mod3_addr_out          <= mod_addr[3];
			modified_sel_out       <= refresh_grant_in ? 4'h0 : sel_mod;
			rotate_bits_out        <= rot_sel;
			write_rot_out          <= rot_byte(write_data_in, rot_sel);
			read_rot_out           <= unrot_byte(read_data_in, rot_sel);
		end
	end

endmodule

`default_nettype wire

/* File: mma_addr_path_asserts.sv */
// Concurrent checks on the address path ports.
`timescale 1ns/10ps
`default_nettype none
module mma_addr_path_chk (
	input wire logic        sys_clk_in,
	input wire logic        rst_in,
	input wire logic        addr_mode_line_high_in,
	input wire logic        addr_mode_line_mid_in,
	input wire logic        addr_mode_line_low_in,
	input wire logic [18:0] main_exchange_bus_in,
	input wire logic [18:0] field_address_reg_in,
	input wire logic        memory_rw_micro_start_in,
	input wire logic        memory_rw_micro_done_in,
	input wire logic        microword_increment_in,
	input wire logic        fetch_flag_in,
	input wire logic        transfer_direction_sign_in,
	input wire logic        refresh_grant_in,
	input wire logic [18:0] memory_address_reg_out,
	input wire logic        data_role_out,
	input wire logic [13:0] mod0_addr_out,
	input wire logic [13:0] mod3_addr_out,
	input wire logic [3:0]  modified_sel_out,
	input wire logic [2:0]  rotate_bits_out
);
	wire [2:0]  md = {addr_mode_line_high_in, addr_mode_line_mid_in, addr_mode_line_low_in};
	wire        pm = !data_role_out && !memory_rw_micro_start_in;
	wire [18:0] ar = memory_address_reg_out;
	wire [18:0] bs = main_exchange_bus_in;
	wire [13:0] n  = ar[18:5];
	wire [1:0]  k  = ar[4:3];
	wire        dv = !fetch_flag_in && !refresh_grant_in;
	wire [18:0] ax = {md[0] ? ar[18:3] - bs[18:3] : ar[18:3] + bs[18:3], ar[2:0]};
	wire [18:0] an = ar + (microword_increment_in ? 19'h10 : 19'h0);
	wire [3:0]  mk = transfer_direction_sign_in ? 4'he << k : (4'h1 << k) - 4'h1;
	wire [13:0] nm = transfer_direction_sign_in ? n - 14'h1 : n + 14'h1;
	wire [2:0]  rb = fetch_flag_in ? 3'h0 : ar[2:0];
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);
	a_load_mode: assert property (pm && md == 3'h2 |=> ar == $past(bs)) else $error("bad load");
	a_add_sub: assert property (pm && (md == 3'h4 || md == 3'h5) |=> ar ==
		$past(ax)) else $error("bad add");
	a_odd_nop: assert property (pm && !(md inside {3'h0, 3'h2, 3'h4, 3'h5}) |=>
		ar == $past(an)) else $error("bad nop");
	a_step_inc: assert property (pm && md == 3'h0 && microword_increment_in |=>
		ar == $past(ar) + 19'h10) else $error("bad step");
	a_rw_load: assert property (!data_role_out && memory_rw_micro_start_in |=>
		ar == $past(field_address_reg_in) && data_role_out) else $error("bad start");
	a_rw_restore: assert property (!data_role_out && memory_rw_micro_start_in
		##1 memory_rw_micro_done_in |=> ar == $past(ar, 2) && !data_role_out) else $error("bad done");
	a_fetch_plain: assert property (fetch_flag_in && !refresh_grant_in |=> mod0_addr_out ==
		$past(n) && mod3_addr_out == $past(n) && modified_sel_out == 4'h0) else $error("bad fetch");
	a_split_mask: assert property (dv |=> modified_sel_out ==
		$past(mk)) else $error("bad mask");
	a_mod3_word: assert property (dv |=> mod3_addr_out == (modified_sel_out[3] ?
		$past(nm) : $past(n))) else $error("bad word");
	a_rot_low: assert property (1'b1 |=>
		rotate_bits_out == $past(rb)) else $error("bad rotate");
	c_rw: cover property (!data_role_out && memory_rw_micro_start_in ##1 memory_rw_micro_done_in);
	c_fetch: cover property (fetch_flag_in);
	c_sub: cover property (md == 3'h5);
endmodule
bind mma_addr_path mma_addr_path_chk chk (.*);
`default_nettype wire

/* File: mma_defs.vh */
// Constants for the memory module address path.
`ifndef MMA_DEFS_VH
`define MMA_DEFS_VH

// Address register geometry.
`define MMA_ADDR_W      19
`define MMA_KEY_W       16
`define MMA_WORD_W      14
`define MMA_ROT_W       3
`define MMA_KEY_LSB     3
`define MMA_WORD_LSB    5
`define MMA_KB_BIT3     3
`define MMA_KB_BIT4     4
`define MMA_INC_BIT     4
`define MMA_MODULES     4

// Mode line codes, ordered high, middle, low.
`define MMA_MODE_NOP    3'h0
`define MMA_MODE_LOAD   3'h2
`define MMA_MODE_ADD    3'h4
`define MMA_MODE_SUB    3'h5

// Reset values.
`define MMA_ADDR_RST    19'h00000
`define MMA_WORD_RST    14'h0000
`define MMA_BYTE_RST    8'h00

`endif

/* File: mma_dist.v */
// Per-module address select terms for the four storage modules.
`timescale 1ns/10ps
`default_nettype none

module mma_dist (
	input  wire       transfer_direction_sign_in,
	input  wire       fetch_flag_in,
	input  wire       key_byte_bit3_in,
	input  wire       key_byte_bit4_in,
	output reg  [3:0] unmodified_sel_a_out,
	output reg  [3:0] unmodified_sel_b_out,
	output reg  [3:0] modified_sel_out
);

	reg [1:0] pos;
	integer   i;

	always @* begin
		pos = {key_byte_bit4_in, key_byte_bit3_in};
		modified_sel_out = 4'h0;
		for (i = 0; i < 4; i = i + 1) begin
			// Forward: modules below the key position take word n+1.
			if (!transfer_direction_sign_in && (i < pos)) begin
				modified_sel_out[i] = 1'b1;
			end
			// Reverse: modules above the key position take word n-1.
			if (transfer_direction_sign_in && (i > pos)) begin
				modified_sel_out[i] = 1'b1;
			end
		end
		// Fetch overrides modification for every module.
		if (fetch_flag_in) begin
			modified_sel_out = 4'h0;
		end
		unmodified_sel_a_out = ~modified_sel_out;
		unmodified_sel_b_out = ~modified_sel_out;
	end

endmodule

`default_nettype wire

/* File: mma_store_model.sv */
// Behavioural stand-in for storage modules 0 and 3 only.
`timescale 1ns/10ps
`default_nettype none
module mma_store_model (
	input  wire logic        sys_clk_in,
	input  wire logic [13:0] m0_in,
	input  wire logic [13:0] m3_in,
	output var  logic [7:0]  rdata_out
);
	always @(posedge sys_clk_in) begin
		rdata_out <= m0_in[7:0] ^ m3_in[7:0];
	end
endmodule
`default_nettype wire

/* File: tb_mma_addr_path.sv */
// Self-checking bench for the memory module address path.
`timescale 1ns/10ps
`default_nettype none
module tb_mma_addr_path;
	logic [18:0] main_exchange_bus_in, field_address_reg_in, memory_address_reg_out, a, s;
	logic [13:0] refresh_addr_in, mod0_addr_out, mod1_addr_out, mod2_addr_out, mod3_addr_out;
	logic [7:0]  write_data_in, read_data_in, write_rot_out, read_rot_out;
	logic [3:0]  modified_sel_out, es;
	logic [2:0]  rotate_bits_out;
	logic        sys_clk_in, rst_in, addr_mode_line_high_in, addr_mode_line_mid_in;
	logic        addr_mode_line_low_in, memory_rw_micro_start_in, memory_rw_micro_done_in;
	logic        microword_increment_in, fetch_flag_in, transfer_direction_sign_in;
	logic        refresh_grant_in, data_role_out;
	int          error_cnt, cmp_count, i, j, d;
	wire  [55:0] ma = {mod3_addr_out, mod2_addr_out, mod1_addr_out, mod0_addr_out};
	mma_addr_path dut (.*);
	mma_store_model mem (.sys_clk_in, .m0_in(mod0_addr_out), .m3_in(mod3_addr_out),
		.rdata_out(read_data_in));
	initial begin
		sys_clk_in = 1'b0;
		forever #2 sys_clk_in = ~sys_clk_in;
	end
	task drive(input [2:0] m, input [18:0] v, input [5:0] p);
		{addr_mode_line_high_in, addr_mode_line_mid_in, addr_mode_line_low_in} <= m;
		main_exchange_bus_in <= v;
		{memory_rw_micro_start_in, memory_rw_micro_done_in, microword_increment_in} <= p[5:3];
		{fetch_flag_in, transfer_direction_sign_in, refresh_grant_in} <= p[2:0];
	endtask
	task op(input [2:0] m, input [18:0] v, input [5:0] p);
		@(posedge sys_clk_in);
		drive(m, v, p);
		@(posedge sys_clk_in);
		drive(3'h0, v, {3'h0, p[2:0]});
		#1;
	endtask
	task chk(input logic [18:0] g, input logic [18:0] e);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task print_verdict;
		$display("errors=%0d compares=%0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (2000) @(posedge sys_clk_in);
		error_cnt++;
		print_verdict;
	end
	initial begin
		drive(3'h0, 19'h0, 6'h00);
		field_address_reg_in = 19'h3c3c5;
		refresh_addr_in = 14'h02a5;
		write_data_in = 8'h01;
		rst_in = 1'b1;
		repeat (3) @(posedge sys_clk_in);
		rst_in <= 1'b0;
		a = 19'h12345;
		op(3'h2, a, 6'h00);
		chk(memory_address_reg_out, a);
		op(3'h4, 19'h00028, 6'h00);
		a = {a[18:3] + 16'h0005, a[2:0]};
		chk(memory_address_reg_out, a);
		op(3'h5, 19'h00048, 6'h00);
		a = {a[18:3] - 16'h0009, a[2:0]};
		chk(memory_address_reg_out, a);
		for (i = 1; i < 8; i++) if (i != 2 && i != 4 && i != 5) begin
			op(i[2:0], 19'h7ffff, 6'h00);
			chk(memory_address_reg_out, a);
		end
		op(3'h0, 19'h0, 6'h08);
		a = a + 19'h10;
		chk(memory_address_reg_out, a);
		s = a;
		op(3'h0, 19'h0, 6'h20);
		chk(memory_address_reg_out, field_address_reg_in);
		chk(data_role_out, 1'b1);
		op(3'h4, 19'h8, 6'h28);
		chk(memory_address_reg_out, field_address_reg_in);
		op(3'h0, 19'h0, 6'h10);
		chk(memory_address_reg_out, s);
		chk(data_role_out, 1'b0);
		@(posedge sys_clk_in);
		drive(3'h0, 19'h0, 6'h20);
		@(posedge sys_clk_in);
		drive(3'h0, 19'h0, 6'h10);
		#1;
		chk(memory_address_reg_out, field_address_reg_in);
		op(3'h0, 19'h0, 6'h00);
		chk(memory_address_reg_out, s);
		chk(data_role_out, 1'b0);
		for (d = 0; d < 2; d++) for (j = 0; j < 4; j++) begin
			op(3'h2, {14'h0100, j[1:0], 3'h0}, {4'h0, d[0], 1'b0});
			op(3'h0, 19'h0, {4'h0, d[0], 1'b0});
			for (i = 0; i < 4; i++) begin
				es[i] = d ? i > j : i < j;
				chk(ma[i*14 +: 14], es[i] ? (d ? 14'h00ff : 14'h0101) : 14'h0100);
			end
			chk(modified_sel_out, es);
		end
		op(3'h2, {14'h0100, 2'h3, 3'h5}, 6'h00);
		op(3'h0, 19'h0, 6'h04);
		for (i = 0; i < 4; i++) chk(ma[i*14 +: 14], 14'h0100);
		chk(modified_sel_out, 4'h0);
		chk(rotate_bits_out, 3'h0);
		op(3'h0, 19'h0, 6'h00);
		chk(rotate_bits_out, 3'h5);
		chk(write_rot_out, 8'h80 >> 5);
		op(3'h0, 19'h0, 6'h01);
		for (i = 0; i < 4; i++) chk(ma[i*14 +: 14], refresh_addr_in);
		chk(memory_address_reg_out, {14'h0100, 2'h3, 3'h5});
		chk(read_rot_out, 8'h40);
		print_verdict;
	end
endmodule
`default_nettype wire
